// [hdl/camask_defines.vh]
`ifndef CAMASK_DEFINES_VH
`define CAMASK_DEFINES_VH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define CAMASK_STRIDE          8'h10
`define CAMASK_OFS_STD_HIGH    4'h0
`define CAMASK_OFS_STD_LOW     4'h4
`define CAMASK_OFS_EXT_HIGH    4'h8
`define CAMASK_OFS_EXT_LOW     4'hC
`define CAMASK_ADDR_TIMING     8'h20
`define CAMASK_ADDR_CONTROL    8'h24
`define CAMASK_NUM_MASKS       2

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define CAMASK_LOW_SID_MSB     7
`define CAMASK_LOW_SID_LSB     5
`define CAMASK_LOW_E17_MSB     1
`define CAMASK_LOW_E17_LSB     0
`define CAMASK_SJW_MSB         7
`define CAMASK_SJW_LSB         6
`define CAMASK_BRP_MSB         5
`define CAMASK_BRP_LSB         0
`define CAMASK_CTL_CONFIG      0
`define CAMASK_CTL_EXTEN_LSB   1
`define CAMASK_CTL_EXTEN_MSB   2

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define CAMASK_TIMING_RESET    8'h00
`define CAMASK_CONTROL_RESET   3'h1

// ----------------------------------------------------------------------
// timing: one quantum is 2 x (prescaler + 1) oscillator periods
// ----------------------------------------------------------------------
`define CAMASK_TQ_FACTOR       2
`define CAMASK_TQ_CNT_W        7

`endif

// [hdl/camask_tq_gen.v]
`timescale 1ns/10ps
`default_nettype none
`include "camask_defines.vh"

module camask_tq_gen
(
    input  wire       hclk,
    input  wire       hresetn,
    input  wire [5:0] quantum_prescaler,
    output reg        time_quantum
);

    reg  [`CAMASK_TQ_CNT_W-1:0] count;
    wire [`CAMASK_TQ_CNT_W-1:0] last;

    // ------------------------------------------------------------------
    // quantum divider: pulse every 2 x (prescaler + 1) clocks
    // ------------------------------------------------------------------
    assign last = {quantum_prescaler, 1'b1};

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            count        <= 7'h00;
            time_quantum <= 1'b0;
        end
        else if (count >= last)
        begin
            count        <= 7'h00;
            time_quantum <= 1'b1;
        end
        else
        begin
            count        <= count + 7'h01;
            time_quantum <= 1'b0;
        end
    end

endmodule // camask_tq_gen
`default_nettype wire

// [hdl/camask_top.v]
// Chosen here: the AHB-Lite register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "camask_defines.vh"

module camask_top
(
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    input  wire        rx_valid,
    input  wire [28:0] rx_id,
    input  wire        rx_ext,
    input  wire [28:0] filter0_id,
    input  wire [28:0] filter1_id,
    output reg         accept_valid,
    output reg  [1:0]  accept_hit,
    output reg         config_mode,
    output reg  [2:0]  resync_jump_width,
    output wire        time_quantum
);

    // ------------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------------
    reg  [7:0] mask_std_high        [0:1];
    reg  [2:0] std_id_mask_low3     [0:1];
    reg  [1:0] ext_id_mask_17_16    [0:1];
    reg  [7:0] ext_id_mask_mid_byte [0:1];
    reg  [7:0] ext_id_mask_low_byte [0:1];
    reg  [7:0] bit_timing_control_one;
    reg  [1:0] filter_extended_enable;

    // ------------------------------------------------------------------
    // bus pipeline state
    // ------------------------------------------------------------------
    reg        wr_pend;
    reg        rd_pend;
    reg  [7:0] ph_addr;
    reg  [31:0] next_rdata;
    wire       take;
    wire       in_masks;
    wire       idx;
    wire [3:0] ofs;
    wire [7:0] wbyte;
    wire       timing_wr;
    wire       control_wr;
    wire [2:0] next_jump_width;
    wire [5:0] quantum_prescaler;

    assign take     = hsel & htrans[1] & hready;
    assign in_masks = ({1'b0, ph_addr} < {`CAMASK_STRIDE, 1'b0}) &&
                      (ph_addr[1:0] == 2'b00);
    assign idx      = ph_addr[4];
    assign ofs      = ph_addr[3:0];
    assign wbyte    = hwdata[7:0];

    // timing register is locked once configuration mode is left
    assign timing_wr  = wr_pend && config_mode &&
                        (ph_addr == `CAMASK_ADDR_TIMING);
    assign control_wr = wr_pend && (ph_addr == `CAMASK_ADDR_CONTROL);

    // ------------------------------------------------------------------
    // address phase capture and response
    // ------------------------------------------------------------------
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend   <= 1'b0;
            rd_pend   <= 1'b0;
            ph_addr   <= 8'h00;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            hresp <= 1'b0;
            if (rd_pend)
            begin
                // read wait state done, data now stands
                rd_pend   <= 1'b0;
                hreadyout <= 1'b1;
                wr_pend   <= 1'b0;
            end
            else if (take)
            begin
                wr_pend   <= hwrite;
                rd_pend   <= ~hwrite;
                ph_addr   <= haddr[7:0];
                hreadyout <= hwrite;
            end
            else if (hready)
            begin
                wr_pend <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // mask registers: no reset, contents undefined after power-up
    // ------------------------------------------------------------------
    always @(posedge hclk)
    begin
        if (wr_pend && in_masks)
        begin
            case (ofs)
                `CAMASK_OFS_STD_HIGH:
                begin
                    mask_std_high[idx] <= wbyte;
                end
                `CAMASK_OFS_STD_LOW:
                begin
                    std_id_mask_low3[idx] <=
                        wbyte[`CAMASK_LOW_SID_MSB:`CAMASK_LOW_SID_LSB];
                    ext_id_mask_17_16[idx] <=
                        wbyte[`CAMASK_LOW_E17_MSB:`CAMASK_LOW_E17_LSB];
                end
                `CAMASK_OFS_EXT_HIGH:
                begin
                    ext_id_mask_mid_byte[idx] <= wbyte;
                end
                `CAMASK_OFS_EXT_LOW:
                begin
                    ext_id_mask_low_byte[idx] <= wbyte;
                end
                default:
                begin
                    mask_std_high[idx] <= mask_std_high[idx];
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // timing and control registers
    // ------------------------------------------------------------------
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            bit_timing_control_one <= `CAMASK_TIMING_RESET;
            config_mode            <= 1'b1;
            filter_extended_enable <= 2'b00;
        end
        else
        begin
            if (timing_wr)
            begin
                bit_timing_control_one <= wbyte;
            end
            if (control_wr)
            begin
                config_mode <= wbyte[`CAMASK_CTL_CONFIG];
                filter_extended_enable <=
                    wbyte[`CAMASK_CTL_EXTEN_MSB:`CAMASK_CTL_EXTEN_LSB];
            end
        end
    end

    // ------------------------------------------------------------------
    // read data mux, registered during the read wait state
    // ------------------------------------------------------------------
    always @*
    begin
        next_rdata = 32'h0000_0000;
        if (in_masks)
        begin
            case (ofs)
                `CAMASK_OFS_STD_HIGH:
                    next_rdata[7:0] = mask_std_high[idx];
                `CAMASK_OFS_STD_LOW:
                    next_rdata[7:0] = {std_id_mask_low3[idx], 3'b000,
                                       ext_id_mask_17_16[idx]};
                `CAMASK_OFS_EXT_HIGH:
                    next_rdata[7:0] = ext_id_mask_mid_byte[idx];
                `CAMASK_OFS_EXT_LOW:
                    next_rdata[7:0] = ext_id_mask_low_byte[idx];
                default:
                    next_rdata = 32'h0000_0000;
            endcase
        end
        else if (ph_addr == `CAMASK_ADDR_TIMING)
        begin
            next_rdata[7:0] = bit_timing_control_one;
        end
        else if (ph_addr == `CAMASK_ADDR_CONTROL)
        begin
            next_rdata[2:0] = {filter_extended_enable, config_mode};
        end
    end

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata <= 32'h0000_0000;
        end
        else if (rd_pend)
        begin
            hrdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------------
    // acceptance compare per mask
    // ------------------------------------------------------------------
    reg  [28:0] full_mask [0:1];
    reg  [28:0] filt      [0:1];
    reg  [1:0]  next_hit;
    integer     m;

    always @*
    begin
        next_hit = 2'b00;
        filt[0]  = filter0_id;
        filt[1]  = filter1_id;
        for (m = 0; m < `CAMASK_NUM_MASKS; m = m + 1)
        begin
            // mask bits line up as eid28..eid0; standard uses top 11
            full_mask[m] = {mask_std_high[m], std_id_mask_low3[m],
                            ext_id_mask_17_16[m], ext_id_mask_mid_byte[m],
                            ext_id_mask_low_byte[m]};
            if (filter_extended_enable[m])
            begin
                next_hit[m] = rx_ext &&
                    (((rx_id ^ filt[m]) & full_mask[m]) == 29'h0);
            end
            else
            begin
                next_hit[m] = !rx_ext &&
                    (((rx_id[10:0] ^ filt[m][28:18]) &
                      full_mask[m][28:18]) == 11'h000);
            end
        end
    end

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            accept_valid <= 1'b0;
            accept_hit   <= 2'b00;
        end
        else
        begin
            accept_valid <= rx_valid;
            accept_hit   <= rx_valid ? next_hit : 2'b00;
        end
    end

    // ------------------------------------------------------------------
    // bit timing outputs
    // ------------------------------------------------------------------
    assign next_jump_width   = {1'b0,
        bit_timing_control_one[`CAMASK_SJW_MSB:`CAMASK_SJW_LSB]}
        + 3'h1;
    assign quantum_prescaler =
        bit_timing_control_one[`CAMASK_BRP_MSB:`CAMASK_BRP_LSB];

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            resync_jump_width <= 3'h1;
        end
        else
        begin
            resync_jump_width <= next_jump_width;
        end
    end

    camask_tq_gen u_tq
    (
        .hclk              (hclk),
        .hresetn           (hresetn),
        .quantum_prescaler (quantum_prescaler),
        .time_quantum      (time_quantum)
    );

endmodule // camask_top
`default_nettype wire

// [tb/camask_chk.sv]
`timescale 1ns/10ps
`default_nettype none
module camask_chk
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        rx_valid,
    input wire logic [28:0] rx_id,
    input wire logic        rx_ext,
    input wire logic [28:0] filter0_id,
    input wire logic [28:0] filter1_id,
    input wire logic        accept_valid,
    input wire logic [1:0]  accept_hit,
    input wire logic        config_mode,
    input wire logic [2:0]  resync_jump_width,
    input wire logic        time_quantum
);
    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire logic rd_req = hsel && htrans[1] && hready && !hwrite;
    wire logic wr_req = hsel && htrans[1] && hready && hwrite;
    property p_resp_okay; hresp == 1'b0; endproperty
    property p_read_wait; rd_req |=> !hreadyout ##1 hreadyout; endproperty
    property p_write_nowait; wr_req |=> hreadyout; endproperty
    property p_rd_upper; rd_req |-> ##2 hrdata[31:8] == 24'h000000;
    endproperty
    property p_acc_on; rx_valid |=> accept_valid; endproperty
    property p_acc_off; !rx_valid |=> !accept_valid; endproperty
    property p_hit_idle; !accept_valid |-> accept_hit == 2'b00; endproperty
    property p_sjw_range; resync_jump_width inside {[3'h1:3'h4]};
    endproperty
    property p_tq_pulse; time_quantum |=> !time_quantum; endproperty
    property p_sjw_locked;
        !config_mode ##1 !config_mode |=> $stable(resync_jump_width);
    endproperty
    a_resp_okay:    assert property (p_resp_okay) else $error("hresp set");
    a_read_wait:    assert property (p_read_wait) else $error("read wait");
    a_write_nowait: assert property (p_write_nowait) else $error("wr wait");
    a_rd_upper:     assert property (p_rd_upper)
        else $error("upper bits");
    a_acc_on:       assert property (p_acc_on)
        else $error("no accept");
    a_acc_off:      assert property (p_acc_off)
        else $error("stray acc");
    a_hit_idle:     assert property (p_hit_idle)
        else $error("stray hit");
    a_sjw_range:    assert property (p_sjw_range)
        else $error("sjw range");
    a_tq_pulse:     assert property (p_tq_pulse)
        else $error("tq width");
    a_sjw_locked:   assert property (p_sjw_locked)
        else $error("sjw chg");
    c_read:  cover property (rd_req);
    c_hit:   cover property (accept_valid && accept_hit != 2'b00);
    c_tq:    cover property (time_quantum);
    c_lock:  cover property (!config_mode && wr_req);
endmodule // camask_chk
bind camask_top camask_chk u_camask_chk (.*);
`default_nettype wire

// [tb/camask_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module camask_tb_top;
    logic        hclk, hresetn, hsel, hwrite, rx_valid, rx_ext;
    logic [31:0] haddr, hwdata, d;
    logic [1:0]  htrans;
    logic [28:0] rx_id;
    wire  [31:0] hrdata;
    wire         hreadyout, hresp, accept_valid, config_mode, time_quantum;
    wire  [1:0]  accept_hit;
    wire  [2:0]  resync_jump_width;
    int          errors, compares, i;

    camask_top u_camask_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .rx_valid(rx_valid),
        .rx_id(rx_id), .rx_ext(rx_ext), .filter0_id({11'h2A5, 18'h00000}),
        .filter1_id(29'h15555555), .accept_valid(accept_valid),
        .accept_hit(accept_hit), .config_mode(config_mode),
        .resync_jump_width(resync_jump_width), .time_quantum(time_quantum));

    initial
    begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end

    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic final_report;
        if (errors == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] s, e);
        compares++;
        if (s !== e)
        begin
            errors++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask

    // waits for an edge with hready high, bounded
    task automatic rdy;
        int n;
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 99);
        if (n >= 99)
        begin
            errors++;
            final_report;
        end
    endtask

    task automatic bus(input logic [7:0] a, input logic w,
                       input logic [7:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'b10;
        hwrite <= w;
        rdy;
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h000000, wd};
        rdy;
        rd = hrdata;
    endtask

    task automatic acc(input logic [28:0] id, input logic x,
                       input logic [1:0] e);
        @(posedge hclk);
        rx_valid <= 1'b1;
        rx_id <= id;
        rx_ext <= x;
        @(posedge hclk);
        rx_valid <= 1'b0;
        @(posedge hclk);
        chk("accept_valid", {31'h0, accept_valid}, 32'h1);
        chk("accept_hit", {30'h0, accept_hit}, {30'h0, e});
    endtask

    // measures pulse to pulse distance of the quantum strobe
    task automatic tq(input int p);
        int n;
        for (n = 0; time_quantum !== 1'b1 && n < 300; n++)
            @(posedge hclk);
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end while (time_quantum !== 1'b1 && n < 300);
        chk("tq_period", n, p);
        if (n >= 300)
            final_report;
    endtask

    // ------------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------------
    initial
    begin
        {hresetn, hsel, hwrite, rx_valid, rx_ext} = 5'h00;
        {haddr, hwdata, htrans, rx_id} = '0;
        errors = 0;
        compares = 0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        bus(8'h20, 1'b0, 8'h00, d);
        chk("timing", d, 32'h0);
        chk("sjw", {29'h0, resync_jump_width}, 32'h1);
        chk("cfg", {31'h0, config_mode}, 32'h1);
        for (i = 0; i < 2; i++)
        begin
            bus(8'(16 * i), 1'b1, 8'(255 * (1 - i)), d);
            bus(8'(16 * i + 4), 1'b1, 8'hFF, d);
            bus(8'(16 * i + 4), 1'b0, 8'h00, d);
            chk("lo", d, 32'hE3);
            bus(8'(16 * i + 4), 1'b1, 8'h1C, d);
            bus(8'(16 * i + 4), 1'b0, 8'h00, d);
            chk("lo", d, 32'h0);
            bus(8'(16 * i + 8), 1'b1, 8'hA5, d);
            bus(8'(16 * i + 8), 1'b0, 8'h00, d);
            chk("eh", d, 32'hA5);
            bus(8'(16 * i + 12), 1'b1, 8'h5A, d);
            bus(8'(16 * i + 12), 1'b0, 8'h00, d);
            chk("el", d, 32'h5A);
        end
        bus(8'h04, 1'b1, 8'hE0, d);
        bus(8'h18, 1'b1, 8'h00, d);
        bus(8'h1C, 1'b1, 8'h00, d);
        for (i = 0; i < 4; i++)
        begin
            bus(8'h20, 1'b1, 8'(65 * i), d);
            bus(8'h20, 1'b0, 8'h00, d);
            chk("tm", d, 32'(65 * i));
            chk("sjw", {29'h0, resync_jump_width}, 32'(i + 1));
            tq(2 * (i + 1));
        end
        bus(8'h20, 1'b1, 8'h7F, d);
        tq(128);
        bus(8'h24, 1'b1, 8'h04, d);
        bus(8'h24, 1'b0, 8'h00, d);
        chk("ctl", d, 32'h4);
        chk("cfg", {31'h0, config_mode}, 32'h0);
        bus(8'h20, 1'b1, 8'h00, d);
        bus(8'h20, 1'b0, 8'h00, d);
        chk("tm", d, 32'h7F);
        chk("sjw", {29'h0, resync_jump_width}, 32'h2);
        acc(29'h2A5, 1'b0, 2'b01);
        acc(29'h2A4, 1'b0, 2'b00);
        acc(29'h2A5, 1'b1, 2'b10);
        bus(8'h1C, 1'b1, 8'h01, d);
        acc(29'h15555555, 1'b1, 2'b10);
        acc(29'h15555554, 1'b1, 2'b00);
        bus(8'h30, 1'b1, 8'hFF, d);
        bus(8'h30, 1'b0, 8'h00, d);
        chk("unmapped", d, 32'h0);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        bus(8'h20, 1'b0, 8'h00, d);
        chk("timing", d, 32'h0);
        chk("sjw", {29'h0, resync_jump_width}, 32'h1);
        chk("cfg", {31'h0, config_mode}, 32'h1);
        final_report;
    end
endmodule // camask_tb_top
`default_nettype wire
